/* File: verilog/lsu_load_store_unit.sv */
`timescale 1ns/1ps
module lsu_load_store_unit
    import lsu_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire lsu_req_t          req,
    input  wire logic [DATA_W-1:0] rf_rdata,
    input  wire logic              bus_ack,
    input  wire logic [DATA_W-1:0] bus_rdata,
    output lsu_bus_t               bus_reg,
    output logic [IDX_W-1:0]       rf_raddr_reg,
    output lsu_rf_wr_t             rf_w_reg,
    output logic                   busy_reg,
    output logic                   done_reg,
    output logic                   branch_reg,
    output logic [DATA_W-1:0]      branch_target_reg,
    output logic                   thumb_bit_reg,
    output logic                   flags_we_reg
);

    typedef enum logic [2:0] {
        LSU_IDLE, LSU_SEL, LSU_ISSUE, LSU_WAIT, LSU_FIN
    } lsu_state_t;

    lsu_state_t        state_reg,  state_next;
    lsu_op_t           op_reg,     op_next;
    lsu_kind_t         kind_reg,   kind_next;
    logic [LIST_W-1:0] list_reg,   list_next;
    logic [DATA_W-1:0] addr_reg,   addr_next;
    logic [DATA_W-1:0] start_reg,  start_next;
    logic [LOW_W-1:0]  base_reg,   base_next;
    logic [LOW_W-1:0]  xfer_reg,   xfer_next;
    logic [IDX_W-1:0]  cur_reg,    cur_next;
    logic              wb_reg,     wb_next;
    logic              pc_hit_reg, pc_hit_next;
    lsu_bus_t          bus_next;
    lsu_rf_wr_t        rf_w_next;
    logic [IDX_W-1:0]  rf_raddr_next;
    logic              done_next, branch_next, thumb_next;
    logic [DATA_W-1:0] target_next;

    function automatic logic [CNT_W-1:0] low_pos(logic [LIST_W-1:0] l);
        logic [CNT_W-1:0] p;
        p = '0;
        for (int i = LIST_W - 1; i >= 0; i--) begin
            if (l[i]) begin
                p = CNT_W'(i);
            end
        end
        return p;
    endfunction

    function automatic logic [CNT_W-1:0] count(logic [LIST_W-1:0] l);
        logic [CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < LIST_W; i++) begin
            c = c + CNT_W'(l[i]);
        end
        return c;
    endfunction

    // narrow data arrives right-justified on bus_rdata
    function automatic logic [DATA_W-1:0] extend(lsu_kind_t k,
                                                 logic [DATA_W-1:0] d);
        case (k)
            LSU_UBYTE: return {24'h00_0000, d[7:0]};
            LSU_UHALF: return {16'h0000, d[15:0]};
            LSU_SBYTE: return {{24{d[7]}}, d[7:0]};
            LSU_SHALF: return {{16{d[15]}}, d[15:0]};
            default:   return d;
        endcase
    endfunction

    logic              multi;
    logic              is_load;
    logic [CNT_W-1:0]  low_idx;
    logic [DATA_W-1:0] n_bytes;

    assign multi   = (op_reg == LSU_OP_BLOCK_LOAD) ||
                     (op_reg == LSU_OP_BLOCK_STORE) ||
                     (op_reg == LSU_OP_PUSH) || (op_reg == LSU_OP_POP);
    assign is_load = (op_reg == LSU_OP_LOAD_REG) ||
                     (op_reg == LSU_OP_LOAD_LIT) ||
                     (op_reg == LSU_OP_BLOCK_LOAD) || (op_reg == LSU_OP_POP);
    assign low_idx = low_pos(list_reg);
    assign n_bytes = DATA_W'(count(req.reg_list)) * WORD_BYTES;

    always_comb begin
        state_next    = state_reg;
        op_next       = op_reg;
        kind_next     = kind_reg;
        list_next     = list_reg;
        addr_next     = addr_reg;
        start_next    = start_reg;
        base_next     = base_reg;
        xfer_next     = xfer_reg;
        cur_next      = cur_reg;
        wb_next       = wb_reg;
        pc_hit_next   = pc_hit_reg;
        bus_next      = bus_reg;
        rf_raddr_next = rf_raddr_reg;
        rf_w_next     = '0;
        done_next     = 1'b0;
        branch_next   = 1'b0;
        target_next   = branch_target_reg;
        thumb_next    = thumb_bit_reg;
        case (state_reg)
            LSU_IDLE: begin
                if (req_valid) begin
                    op_next     = req.op;
                    kind_next   = req.kind;
                    base_next   = req.base_reg;
                    xfer_next   = req.transfer_reg;
                    pc_hit_next = 1'b0;
                    list_next   = req.reg_list;
                    wb_next     = req.writeback;
                    state_next  = LSU_SEL;
                    case (req.op)
                        LSU_OP_LOAD_REG, LSU_OP_STORE_REG: begin
                            addr_next = req.base_val + req.offset_val;
                            list_next = SINGLE_LIST;
                        end
                        LSU_OP_LOAD_LIT: begin
                            addr_next = (req.pc_val & ALIGN_MASK) +
                                        (DATA_W'(req.lit_words) * WORD_BYTES);
                            list_next = SINGLE_LIST;
                            kind_next = LSU_WORD;
                        end
                        LSU_OP_PUSH: begin
                            addr_next = req.stack_pointer - n_bytes;
                            wb_next   = 1'b1;
                        end
                        LSU_OP_POP: begin
                            addr_next = req.stack_pointer;
                            wb_next   = 1'b1;
                        end
                        default: begin
                            addr_next = req.base_val;
                        end
                    endcase
                    start_next = addr_next;
                end
            end
            LSU_SEL: begin
                if (!multi) begin
                    cur_next = {1'b0, xfer_reg};
                end else if (low_idx == CNT_W'(HIGH_BIT)) begin
                    cur_next = (op_reg == LSU_OP_PUSH) ? LR_IDX : PC_IDX;
                end else begin
                    cur_next = {1'b0, low_idx[LOW_W-1:0]};
                end
                rf_raddr_next = cur_next;
                state_next    = LSU_ISSUE;
            end
            // one bus access at a time
            LSU_ISSUE: begin
                bus_next.req  = 1'b1;
                bus_next.we   = !is_load;
                bus_next.addr = addr_reg;
                case (kind_reg)
                    LSU_UBYTE, LSU_SBYTE: begin
                        bus_next.size  = LSU_SZ_BYTE;
                        bus_next.wdata = {24'h00_0000, rf_rdata[7:0]};
                    end
                    LSU_UHALF, LSU_SHALF: begin
                        bus_next.size  = LSU_SZ_HALF;
                        bus_next.wdata = {16'h0000, rf_rdata[15:0]};
                    end
                    default: begin
                        bus_next.size  = LSU_SZ_WORD;
                        bus_next.wdata = rf_rdata;
                    end
                endcase
                state_next = LSU_WAIT;
            end
            LSU_WAIT: begin
                if (bus_ack) begin
                    bus_next.req = 1'b0;
                    // pc value kept for the closing branch
                    if (is_load && cur_reg == PC_IDX) begin
                        pc_hit_next = 1'b1;
                        target_next = bus_rdata & THUMB_MASK;
                        thumb_next  = bus_rdata[0];
                    end else if (is_load) begin
                        rf_w_next.we   = 1'b1;
                        rf_w_next.addr = cur_reg;
                        rf_w_next.data = extend(kind_reg, bus_rdata);
                    end
                    addr_next = addr_reg + WORD_BYTES;
                    list_next = list_reg & ~(LIST_W'(1) << low_idx);
                    state_next = (list_next == '0) ? LSU_FIN : LSU_SEL;
                end
            end
            LSU_FIN: begin
                if (multi && wb_reg) begin
                    rf_w_next.we   = 1'b1;
                    rf_w_next.addr = (op_reg == LSU_OP_PUSH ||
                                      op_reg == LSU_OP_POP) ?
                                     SP_IDX : {1'b0, base_reg};
                    rf_w_next.data = (op_reg == LSU_OP_PUSH) ?
                                     start_reg : addr_reg;
                end
                branch_next = pc_hit_reg;
                done_next   = 1'b1;
                state_next  = LSU_IDLE;
            end
            default: begin
                state_next = LSU_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg         <= LSU_IDLE;
            op_reg            <= LSU_OP_LOAD_REG;
            kind_reg          <= LSU_WORD;
            list_reg          <= '0;
            addr_reg          <= '0;
            start_reg         <= '0;
            base_reg          <= '0;
            xfer_reg          <= '0;
            cur_reg           <= '0;
            wb_reg            <= 1'b0;
            pc_hit_reg        <= 1'b0;
            bus_reg           <= '0;
            rf_raddr_reg      <= '0;
            rf_w_reg          <= '0;
            busy_reg          <= 1'b0;
            done_reg          <= 1'b0;
            branch_reg        <= 1'b0;
            branch_target_reg <= '0;
            thumb_bit_reg     <= 1'b0;
            flags_we_reg      <= 1'b0;
        end else begin
            state_reg         <= state_next;
            op_reg            <= op_next;
            kind_reg          <= kind_next;
            list_reg          <= list_next;
            addr_reg          <= addr_next;
            start_reg         <= start_next;
            base_reg          <= base_next;
            xfer_reg          <= xfer_next;
            cur_reg           <= cur_next;
            wb_reg            <= wb_next;
            pc_hit_reg        <= pc_hit_next;
            bus_reg           <= bus_next;
            rf_raddr_reg      <= rf_raddr_next;
            rf_w_reg          <= rf_w_next;
            busy_reg          <= (state_next != LSU_IDLE);
            done_reg          <= done_next;
            branch_reg        <= branch_next;
            branch_target_reg <= target_next;
            thumb_bit_reg     <= thumb_next;
            flags_we_reg      <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    flags_never_a: assert property (!flags_we_reg)
        else $error("flag write from load/store unit");

    stall_hold_a: assert property (
        (state_reg == LSU_IDLE && req_valid) |=> busy_reg [*3])
        else $error("pipeline not stalled after accept");

    sequence ack_more_s;
        bus_reg.req && bus_ack && multi && (list_next != '0);
    endsequence
    block_step_a: assert property (
        ack_more_s |-> ##3 (bus_reg.req &&
            bus_reg.addr == $past(bus_reg.addr, 3) + WORD_BYTES))
        else $error("block address step is not four bytes");

    signed_byte_a: assert property (
        (bus_reg.req && bus_ack && op_reg == LSU_OP_LOAD_REG &&
         kind_reg == LSU_SBYTE) |=>
        (rf_w_reg.we && rf_w_reg.data[31:8] == {24{rf_w_reg.data[7]}}))
        else $error("signed byte not sign extended");

    reg_addr_a: assert property (
        (state_reg == LSU_IDLE && req_valid &&
         req.op == LSU_OP_LOAD_REG) |-> ##3
        (bus_reg.req && bus_reg.addr == $past(req.base_val, 3) +
                                        $past(req.offset_val, 3)))
        else $error("register offset address wrong");

    push_sp_a: assert property (
        (state_reg == LSU_FIN && op_reg == LSU_OP_PUSH) |=>
        (rf_w_reg.we && rf_w_reg.addr == SP_IDX &&
         rf_w_reg.data == $past(start_reg)))
        else $error("push stack pointer update wrong");

    pop_branch_a: assert property (
        (state_reg == LSU_FIN && pc_hit_reg) |=>
        (branch_reg && done_reg && !busy_reg))
        else $error("pop into pc did not branch on completion");

    byte_store_a: assert property (
        (state_reg == LSU_ISSUE && !is_load && kind_reg == LSU_UBYTE) |=>
        (bus_reg.wdata[31:8] == 24'h00_0000 && bus_reg.size == LSU_SZ_BYTE))
        else $error("byte store carries more than low byte");

endmodule // lsu_load_store_unit

/* File: verilog/lsu_pkg.sv */
package lsu_pkg;

    localparam int          DATA_W      = 32;
    localparam int          IDX_W       = 4;
    localparam int          LOW_W       = 3;
    localparam int          LIST_W      = 9;
    localparam int          LIT_W       = 8;
    localparam int          CNT_W       = 4;
    // list bit that stands for the link or program counter register
    localparam int          HIGH_BIT    = 8;
    localparam logic [3:0]  SP_IDX      = 4'hD;
    localparam logic [3:0]  LR_IDX      = 4'hE;
    localparam logic [3:0]  PC_IDX      = 4'hF;
    localparam logic [31:0] WORD_BYTES  = 32'h4;
    localparam logic [31:0] ALIGN_MASK  = 32'hFFFF_FFFC;
    localparam logic [31:0] THUMB_MASK  = 32'hFFFF_FFFE;
    localparam logic [8:0]  SINGLE_LIST = 9'h001;

    typedef enum logic [2:0] {
        LSU_OP_LOAD_REG,
        LSU_OP_STORE_REG,
        LSU_OP_LOAD_LIT,
        LSU_OP_BLOCK_LOAD,
        LSU_OP_BLOCK_STORE,
        LSU_OP_PUSH,
        LSU_OP_POP
    } lsu_op_t;

    // word, unsigned_byte_load / byte_store, unsigned_half_load /
    // half_store, signed_byte_load, signed_half_load
    typedef enum logic [2:0] {
        LSU_WORD,
        LSU_UBYTE,
        LSU_UHALF,
        LSU_SBYTE,
        LSU_SHALF
    } lsu_kind_t;

    typedef enum logic [1:0] {
        LSU_SZ_BYTE,
        LSU_SZ_HALF,
        LSU_SZ_WORD
    } lsu_size_t;

    typedef struct packed {
        lsu_op_t               op;
        lsu_kind_t             kind;
        logic [LOW_W-1:0]      transfer_reg;
        logic [LOW_W-1:0]      base_reg;
        logic [LOW_W-1:0]      offset_reg;
        logic [LIST_W-1:0]     reg_list;
        logic                  writeback;
        logic [LIT_W-1:0]      lit_words;
        logic [DATA_W-1:0]     base_val;
        logic [DATA_W-1:0]     offset_val;
        logic [DATA_W-1:0]     stack_pointer;
        logic [DATA_W-1:0]     pc_val;
    } lsu_req_t;

    typedef struct packed {
        logic                  req;
        logic                  we;
        lsu_size_t             size;
        logic [DATA_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } lsu_bus_t;

    typedef struct packed {
        logic                  we;
        logic [IDX_W-1:0]      addr;
        logic [DATA_W-1:0]     data;
    } lsu_rf_wr_t;

endpackage

/* File: sim/lsu_mem_model.sv */
`timescale 1ns/1ps
module lsu_mem_model
    import lsu_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire lsu_bus_t          bus,
    input  wire logic [1:0]        lat,
    output logic                   ack,
    output logic [DATA_W-1:0]      rdata
);
    logic [31:0] mem [512];
    logic [1:0]  wait_cnt;
    logic [8:0]  idx;
    logic [4:0]  sh;

    assign idx = bus.addr[10:2];
    assign sh  = {bus.addr[1:0], 3'b000};

    // lanes above a byte or half are left as they are, not cleared
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack      <= 1'b0;
            wait_cnt <= 2'h0;
            rdata    <= 32'hA5A5_A5A5;
        end else if (bus.req && !ack && wait_cnt == lat) begin
            ack      <= 1'b1;
            wait_cnt <= 2'h0;
            rdata    <= mem[idx] >> sh;
            if (bus.we) begin
                case (bus.size)
                    LSU_SZ_BYTE: mem[idx][sh +: 8] <= bus.wdata[7:0];
                    LSU_SZ_HALF: mem[idx][sh +: 16] <= bus.wdata[15:0];
                    default:     mem[idx] <= bus.wdata;
                endcase
            end
        end else begin
            ack      <= 1'b0;
            wait_cnt <= (bus.req && !ack) ? wait_cnt + 2'h1 : 2'h0;
            // stale read data never looks valid between answers
            rdata    <= ~rdata;
        end
    end
endmodule // lsu_mem_model

/* File: sim/lsu_load_store_unit_tb.sv */
`timescale 1ns/1ps
module lsu_load_store_unit_tb
    import lsu_pkg::*;
;
    typedef struct {
        lsu_op_t     op;
        lsu_kind_t   kind;
        logic [31:0] addr;
        logic [31:0] exp;
    } lsu_tb_row_t;

    logic              core_clk;
    logic              rst;
    logic              req_valid;
    lsu_req_t          req;
    logic [31:0]       rf_rdata;
    logic              bus_ack;
    logic [31:0]       bus_rdata;
    lsu_bus_t          bus_reg;
    logic [3:0]        rf_raddr_reg;
    lsu_rf_wr_t        rf_w_reg;
    logic              busy_reg;
    logic              done_reg;
    logic              branch_reg;
    logic [31:0]       branch_target_reg;
    logic              thumb_bit_reg;
    logic              flags_we_reg;
    logic [1:0]        mem_lat;
    logic [31:0]       rf [16];
    int                err_total;
    int                num_checks;
    int                acks;
    int                cyc;
    lsu_req_t          r;
    lsu_tb_row_t       rows [9] = '{
        '{LSU_OP_LOAD_REG,  LSU_WORD,  32'h0000_0100, 32'h8081_F2F3},
        '{LSU_OP_LOAD_REG,  LSU_UBYTE, 32'h0000_0103, 32'h0000_0080},
        '{LSU_OP_LOAD_REG,  LSU_UHALF, 32'h0000_0102, 32'h0000_8081},
        '{LSU_OP_LOAD_REG,  LSU_SBYTE, 32'h0000_0101, 32'hFFFF_FFF2},
        '{LSU_OP_LOAD_REG,  LSU_SHALF, 32'h0000_0100, 32'hFFFF_F2F3},
        '{LSU_OP_LOAD_REG,  LSU_SBYTE, 32'h0000_0100, 32'hFFFF_FFF3},
        '{LSU_OP_STORE_REG, LSU_WORD,  32'h0000_0200, 32'hA5B6_C7D8},
        '{LSU_OP_STORE_REG, LSU_UBYTE, 32'h0000_0203, 32'hD800_0000},
        '{LSU_OP_STORE_REG, LSU_UHALF, 32'h0000_0202, 32'hC7D8_0000}};

    lsu_load_store_unit i_lsu_load_store_unit (.core_clk(core_clk),
        .rst(rst), .req_valid(req_valid), .req(req), .rf_rdata(rf_rdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_reg(bus_reg),
        .rf_raddr_reg(rf_raddr_reg), .rf_w_reg(rf_w_reg),
        .busy_reg(busy_reg), .done_reg(done_reg), .branch_reg(branch_reg),
        .branch_target_reg(branch_target_reg),
        .thumb_bit_reg(thumb_bit_reg), .flags_we_reg(flags_we_reg));

    lsu_mem_model i_lsu_mem_model (.core_clk(core_clk), .rst(rst),
        .bus(bus_reg), .lat(mem_lat), .ack(bus_ack), .rdata(bus_rdata));

    assign rf_rdata = rf[rf_raddr_reg];

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rf_w_reg.we === 1'b1) rf[rf_w_reg.addr] <= rf_w_reg.data;
        if (bus_ack === 1'b1) acks++;
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    always @(negedge core_clk) begin
        if (!rst && flags_we_reg !== 1'b0) begin
            err_total++;
            $display("Error at %0t: condition flags written", $time);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic run(input lsu_req_t q, input int n, input logic brn);
        int k;
        acks = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req       <= q;
        @(posedge core_clk);
        req_valid <= 1'b0;
        for (k = 0; k < 300; k++) begin
            @(negedge core_clk);
            if (done_reg === 1'b1) break;
        end
        chk({31'h0, done_reg}, 32'h1);
        chk(32'(acks), 32'(n));
        chk({31'h0, branch_reg}, {31'h0, brn});
        // base or stack pointer write lands one edge after done
        @(negedge core_clk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        mem_lat = 2'h0;
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        for (int i = 0; i < 16; i++) rf[i] = 32'h0;
        i_lsu_mem_model.mem[9'h040] = 32'h8081_F2F3;
        i_lsu_mem_model.mem[9'h13F] = 32'h1357_9BDF;
        rf[1] = 32'hA5B6_C7D8;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // table addresses are aligned to their access size
        for (int i = 0; i < 9; i++) begin
            r = '0;
            r.op = rows[i].op;
            r.kind = rows[i].kind;
            r.transfer_reg = (rows[i].op == LSU_OP_STORE_REG) ? 3'h1 : 3'h4;
            r.base_reg = 3'h2;
            r.offset_reg = 3'h7;
            r.base_val = rows[i].addr - 32'h0000_0130;
            r.offset_val = 32'h0000_0130;
            mem_lat = 2'(i);
            i_lsu_mem_model.mem[9'h080] = 32'h0;
            run(r, 1, 1'b0);
            if (rows[i].op == LSU_OP_STORE_REG)
                chk(i_lsu_mem_model.mem[9'h080], rows[i].exp);
            else
                chk(rf[4], rows[i].exp);
            $display("row %0d done", i);
        end
        r = '0;
        r.op = LSU_OP_LOAD_LIT;
        r.transfer_reg = 3'h7;
        r.pc_val = 32'h0000_0102;
        r.lit_words = 8'hFF;
        run(r, 1, 1'b0);
        chk(rf[7], 32'h1357_9BDF);
        $display("literal load done");
        // low regs, aligned base, writeback requested
        // base kept out of the stored list
        rf[0] = 32'h1111_1111;
        rf[2] = 32'h2222_2222;
        rf[5] = 32'h5555_5555;
        r = '0;
        r.op = LSU_OP_BLOCK_STORE;
        r.base_reg = 3'h6;
        r.base_val = 32'h0000_0300;
        r.reg_list = 9'h025;
        r.writeback = 1'b1;
        mem_lat = 2'h2;
        run(r, 3, 1'b0);
        chk(i_lsu_mem_model.mem[9'h0C0], 32'h1111_1111);
        chk(i_lsu_mem_model.mem[9'h0C2], 32'h5555_5555);
        chk(rf[6], 32'h0000_030C);
        $display("block store done");
        // base in list, so no writeback
        r.op = LSU_OP_BLOCK_LOAD;
        r.base_reg = 3'h1;
        r.reg_list = 9'h00A;
        r.writeback = 1'b0;
        run(r, 2, 1'b0);
        chk(rf[1], 32'h1111_1111);
        chk(rf[3], 32'h2222_2222);
        $display("block load done");
        // push lists a low reg and link reg
        rf[14] = 32'h0000_1235;
        r = '0;
        r.op = LSU_OP_PUSH;
        r.reg_list = 9'h104;
        r.stack_pointer = 32'h0000_0400;
        run(r, 2, 1'b0);
        chk(i_lsu_mem_model.mem[9'h0FE], 32'h2222_2222);
        chk(i_lsu_mem_model.mem[9'h0FF], 32'h0000_1235);
        chk(rf[13], 32'h0000_03F8);
        $display("push done");
        r.op = LSU_OP_POP;
        r.reg_list = 9'h101;
        r.stack_pointer = 32'h0000_03F8;
        run(r, 2, 1'b1);
        chk(rf[0], 32'h2222_2222);
        chk(rf[13], 32'h0000_0400);
        chk(branch_target_reg, 32'h0000_1234);
        chk({31'h0, thumb_bit_reg}, 32'h1);
        $display("pop done");
        // abort in mid transfer, then the unit must start cleanly
        mem_lat = 2'h3;
        @(posedge core_clk);
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b1;
        @(negedge core_clk);
        chk({busy_reg, done_reg, bus_reg.req}, 32'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        r = '0;
        r.transfer_reg = 3'h5;
        r.base_val = 32'h0000_0100;
        run(r, 1, 1'b0);
        chk(rf[5], 32'h8081_F2F3);
        $display("reset abort done");
        summarize();
    end
endmodule // lsu_load_store_unit_tb
